// File: dv/ssm_chk.sv
/* Port checker of ssm_top.
   Assumes binding to ssm_top by port name. */
`timescale 1ns/1ps
module ssm_chk (
  // Clocks and reset
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  input wire logic                  spi_sck_i,
  // Link pins
  input wire logic                  spi_cs_n_i,
  input wire logic                  hold_n_i,
  input wire logic                  spi_so_o,
  input wire logic                  spi_so_oe_n_o,
  // Log side
  input wire logic                  wr_valid_o,
  input wire logic                  wr_ready_i,
  input wire ssm_pkg::ssm_wr_word_t wr_word_o,
  input wire logic                  wr_drop_o,
  input wire logic                  mode3_o
);
  import ssm_pkg::*;
  logic so_hi;
  // Output level at each rise
  always_ff @(posedge spi_sck_i) so_hi <= spi_so_o;
  property p_cs_float;
    @(posedge sys_clk_i) disable iff (rst_i) spi_cs_n_i |-> spi_so_oe_n_o;
  endproperty
  a_cs_float: assert property (p_cs_float)
    else $error("output driven while deselected");
  property p_hold_float;
    @(posedge sys_clk_i) disable iff (rst_i) !hold_n_i |-> spi_so_oe_n_o;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("output driven while paused");
  property p_hold_frz;
    @(posedge sys_clk_i) disable iff (rst_i) !hold_n_i && !$past(hold_n_i) |-> $stable(spi_so_o);
  endproperty
  a_hold_frz: assert property (p_hold_frz)
    else $error("output moved while paused");
  property p_so_fall;
    @(negedge spi_sck_i) disable iff (rst_i) !spi_so_oe_n_o |-> spi_so_o == so_hi;
  endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("output moved on a rising edge");
  property p_mode_sel;
    @(posedge sys_clk_i) disable iff (rst_i) $changed(mode3_o) |-> !spi_cs_n_i;
  endproperty
  a_mode_sel: assert property (p_mode_sel)
    else $error("mode moved without a selection");
  property p_log_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_word_o);
  endproperty
  a_log_hold: assert property (p_log_hold)
    else $error("log entry lost before taken");
  property p_drop_keep;
    @(posedge sys_clk_i) disable iff (rst_i) wr_drop_o |=> wr_drop_o;
  endproperty
  a_drop_keep: assert property (p_drop_keep)
    else $error("drop flag cleared");
  property p_drop_full;
    @(posedge sys_clk_i) disable iff (rst_i) $rose(wr_drop_o) |-> wr_valid_o;
  endproperty
  a_drop_full: assert property (p_drop_full)
    else $error("drop flag with empty log");
endmodule

// File: dv/ssm_master.sv
/* Serial master model: mode 0/3 byte transfers and pause.
   Assumes one task call at a time from the bench. */
`timescale 1ns/1ps
module ssm_master (
  // Link outputs
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      hold_n_o,
  output logic      wp_n_o,
  // Link inputs
  input wire logic  so_i,
  input wire logic  so_oe_n_i
);
  logic m3;
  initial
  begin
    {sck_o, cs_n_o, si_o, hold_n_o, wp_n_o, m3} = 6'h1e;
  end
  // idle clock level before select; fresh select
  task automatic sel(input logic m);
    m3 = m;
    sck_o = m;
    #62.5 cs_n_o = 0;
    #62.5;
  endtask
  // release; data line inverted once released
  task automatic desel();
    #62.5 cs_n_o = 1;
    si_o = ~si_o;
    #125;
  endtask
  // msb first; 8 MHz clock; whole bytes
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      sck_o = 0;
      si_o = d[i];
      #62.5 sck_o = 1;
      q[i] = so_oe_n_i ? 1'bx : so_i;
      #62.5;
    end
    sck_o = m3;
  endtask
  // pause moved with clock low; clock and select wiggled meanwhile
  task automatic pause();
    #30 hold_n_o = 0;
    repeat (3)
    begin
      #62.5 {sck_o, cs_n_o} = 2'h3;
      #62.5 {sck_o, cs_n_o} = 2'h0;
    end
    #62.5 hold_n_o = 1;
    #62.5;
  endtask
endmodule

// File: dv/ssm_top_test.sv
/* Self-checking bench of ssm_top.
   Assumes ssm_chk and ssm_master are compiled first. */
`timescale 1ns/1ps
module ssm_top_test;
  import ssm_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, wr_ready_i = 0, stall = 0;
  logic sck, cs_n, si, so, oe_n, hold_n, wp_n, wr_valid_o, wr_drop_o, mode3_o;
  ssm_wr_word_t wr_word_o, exp_q[$];
  logic [31:0] rs = 33825, rr = 33825;
  logic [7:0] mem [int];
  logic [7:0] q;
  logic [17:0] a;
  int miscompares = 0, total_checks = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  ssm_master m (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
    .wp_n_o(wp_n), .so_i(so), .so_oe_n_i(oe_n));
  ssm_top #(.FIFO_DEPTH(8)) uut (.sys_clk_i, .rst_i, .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_si_i(si), .spi_so_o(so), .spi_so_oe_n_o(oe_n), .hold_n_i(hold_n), .wp_n_i(wp_n),
    .wr_valid_o, .wr_ready_i, .wr_word_o, .wr_drop_o, .mode3_o);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [17:0] ea(input logic [17:0] b, input int i);
    return 18'(b + 18'(i));
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Random ready unless stalled; entries matched in order
  always @(posedge sys_clk_i)
  begin
    rr = xs(rr);
    if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1)
      chk("log", 32'(wr_word_o), 32'(exp_q.pop_front()));
    wr_ready_i <= !stall && rr[3];
  end
  // Opcode, address with random top bits
  task automatic hdr(input logic [7:0] op, input logic [17:0] b, input logic md);
    rs = xs(rs);
    m.sel(md);
    m.xb(op, q);
    m.xb({rs[7:2], b[17:16]}, q);
    m.xb(b[15:8], q);
    m.xb(b[7:0], q);
    chk("mode", 32'(mode3_o), 32'(md));
  endtask
  task automatic wr(input logic [17:0] b, input int n, input logic md);
    hdr(8'h02, b, md);
    for (int i = 0; i < n; i++)
    begin
      rs = xs(rs);
      m.xb(rs[15:8], q);
      mem[ea(b, i)] = rs[15:8];
      exp_q.push_back({ea(b, i), rs[15:8]});
    end
    m.desel();
  endtask
  // Read back at once after the write, optional pause
  task automatic rd(input logic [7:0] op, input logic [17:0] b, input int n, input logic md);
    hdr(op, b, md);
    if (op == 8'h0b)
      m.xb(8'h00, q);
    for (int i = 0; i < n; i++)
    begin
      if (!md && i == 1)
        m.pause();
      m.xb(8'h00, q);
      chk("rd", 32'(q), 32'(mem[ea(b, i)]));
    end
    m.desel();
  endtask
  task automatic drain();
    for (int k = 0; k < 400 && exp_q.size() > 0; k++)
      @(posedge sys_clk_i);
    chk("left", exp_q.size(), 0);
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 0;
    @(posedge sys_clk_i);
    wr(18'h3fffe, 4, 0);
    rd(8'h03, 18'h3fffe, 4, 1);
    rd(8'h0b, 18'h3fffe, 4, 0);
    a = rs[17:0];
    wr(a, 3, 1);
    rd(8'h03, a, 3, 0);
    m.sel(0);
    m.xb(8'h02, q);
    m.xb(8'h00, q);
    m.desel();
    m.sel(0);
    m.xb(8'h5a, q);
    repeat (5) m.xb(8'h02, q);
    chk("float", 32'(oe_n), 1);
    m.desel();
    for (int k = 0; k < 2; k++)
    begin
      m.wp_n_o = k[0];
      m.sel(0);
      m.xb(8'h01, q);
      m.xb(8'h80, q);
      m.desel();
    end
    drain();
    chk("drop", 32'(wr_drop_o), 0);
    stall = 1;
    wr(a + 18'h40, 10, 0);
    repeat (10) @(posedge sys_clk_i);
    chk("drop", 32'(wr_drop_o), 1);
    // Ninth report is overwritten by the tenth while the log is full
    exp_q.delete(8);
    stall = 0;
    drain();
    report_and_stop();
  end
  initial
  begin
    #400us;
    miscompares++;
    report_and_stop();
  end
endmodule
bind ssm_top ssm_chk chk_i (.*);

// File: hw/ssm_pkg.sv
/*
 * Types of the serial memory slave.
 * Assumes ssm_regs.svh is on the include path.
 */
`include "ssm_regs.svh"

package ssm_pkg;

  // Link-side command sequencing
  typedef enum logic [2:0]
  {
    SSM_OPCODE = 3'b000,
    SSM_ADDR   = 3'b001,
    SSM_DUMMY  = 3'b010,
    SSM_WDATA  = 3'b011,
    SSM_RDATA  = 3'b100,
    SSM_STWR   = 3'b101,
    SSM_IGNORE = 3'b110
  } ssm_state_t;

  // One completed byte write, reported to the system side
  typedef struct packed
  {
    logic [`SSM_ADDR_BITS-1:0] addr;
    logic [7:0]                data;
  } ssm_wr_word_t;

endpackage

// File: hw/ssm_regs.svh
/*
 * Constants of the serial memory slave: opcodes, field positions,
 * widths and the write-log FIFO depth.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SSM_OPC_READ      8'h03
`define SSM_OPC_WRITE     8'h02
`define SSM_OPC_FAST_READ 8'h0b
`define SSM_OPC_WR_STATUS 8'h01

// ----------------------------------------------------------------
// Fields and widths
// ----------------------------------------------------------------
`define SSM_ADDR_BITS     18
`define SSM_ADDR_FIELD    24
`define SSM_BYTE_LAST     3'h7
`define SSM_ADDR_LAST     5'h17
`define SSM_PPEN_POS      7
`define SSM_STATUS_RST    8'h00
`define SSM_FIFO_DEPTH    8
`define SSM_SCK_MAX_MHZ   25

`endif

// File: hw/ssm_top.sv
/* Serial memory slave: mode 0/3 front end, byte array, protected status
 * register, write log toward the system clock. Assumes the master moves
 * pause only while the serial clock is low and reselects per command. */
// Behaviour
// - Sample input on rise, drive on fall
// - Serial clock up to 25 MHz, stoppable
// - Deselected: idle, ignore inputs, output floats
// - Serial clock effective only while selected
// - Output driven only for read data
// - Pin protect refuses status writes
// - Pause freezes clock and select
// - 262144 byte locations, serial access
// - Opcode, three address bytes, then data
// - Low 18 address bits used
// - Writes complete at bus speed
// - Clock level at select picks mode
// - Most significant bit first
// - Read, write, fast read opcodes
// - Unknown opcode: ignore until reselect
`timescale 1ns/1ps
`include "ssm_regs.svh"
// ----------------------------------------------------------------
// Write-log FIFO
// ----------------------------------------------------------------
module ssm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  // Handshakes and flags
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end
  // Pointers and occupancy
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module ssm_top #(
  parameter int FIFO_DEPTH = `SSM_FIFO_DEPTH
)(
  // System clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // Serial link
  input  wire logic                 spi_sck_i,
  input  wire logic                 spi_cs_n_i,
  input  wire logic                 spi_si_i,
  output logic                      spi_so_o,
  output logic                      spi_so_oe_n_o,
  input  wire logic                 hold_n_i,
  input  wire logic                 wp_n_i,
  // Write log toward the system
  output logic                      wr_valid_o,
  input  wire logic                 wr_ready_i,
  output ssm_pkg::ssm_wr_word_t     wr_word_o,
  output logic                      wr_drop_o,
  output logic                      mode3_o
);
  import ssm_pkg::*;
  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic [7:0]               array [2**`SSM_ADDR_BITS];
  ssm_state_t               state;
  logic [4:0]               bit_cnt;
  logic [23:0]              shift;
  logic [7:0]               opcode;
  logic [`SSM_ADDR_BITS-1:0] addr;
  logic [7:0]               rd_byte;
  logic [7:0]               status;
  logic                     link_rst;
  logic                     rise_ok;
  logic [23:0]              next_shift;
  logic                     byte_end;
  logic                     wr_strobe;
  ssm_wr_word_t             link_word;
  logic                     link_tgl;
  logic                     mode3_link;
  logic                     so_q;
  logic                     oe_n_q;
  assign link_rst = rst_i | (spi_cs_n_i & hold_n_i);
  assign rise_ok    = hold_n_i;
  assign next_shift = {shift[22:0], spi_si_i};
  assign byte_end   = (bit_cnt[2:0] == `SSM_BYTE_LAST);
  assign wr_strobe  = rise_ok && (state == SSM_WDATA) && byte_end;
  always_ff @(negedge spi_cs_n_i or posedge rst_i)
  begin
    if (rst_i)
      mode3_link <= 1'b0;
    else if (hold_n_i)
      mode3_link <= spi_sck_i;
  end
  always_ff @(posedge spi_sck_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      state   <= SSM_OPCODE;
      bit_cnt <= '0;
      shift   <= '0;
      opcode  <= '0;
      addr    <= '0;
      rd_byte <= '0;
    end
    else if (rise_ok)
    begin
      shift   <= next_shift;
      bit_cnt <= bit_cnt + 5'h01;
      unique case (state)
        SSM_OPCODE:
          if (byte_end)
          begin
            bit_cnt <= '0;
            opcode  <= next_shift[7:0];
            if (next_shift[7:0] == `SSM_OPC_READ ||
                next_shift[7:0] == `SSM_OPC_WRITE ||
                next_shift[7:0] == `SSM_OPC_FAST_READ)
              state <= SSM_ADDR;
            else if (next_shift[7:0] == `SSM_OPC_WR_STATUS)
              state <= SSM_STWR;
            else
              state <= SSM_IGNORE;
          end
        SSM_ADDR:
          if (bit_cnt == `SSM_ADDR_LAST)
          begin
            bit_cnt <= '0;
            addr    <= next_shift[`SSM_ADDR_BITS-1:0];
            rd_byte <= array[next_shift[`SSM_ADDR_BITS-1:0]];
            if (opcode == `SSM_OPC_WRITE)
              state <= SSM_WDATA;
            else if (opcode == `SSM_OPC_FAST_READ)
              state <= SSM_DUMMY;
            else
              state <= SSM_RDATA;
          end
        SSM_DUMMY:
          if (byte_end)
          begin
            bit_cnt <= '0;
            state   <= SSM_RDATA;
          end
        SSM_WDATA:
          if (byte_end)
          begin
            bit_cnt <= '0;
            addr    <= addr + 1'b1;
          end
        SSM_RDATA:
          if (byte_end)
          begin
            bit_cnt <= '0;
            addr    <= addr + 1'b1;
            rd_byte <= array[addr + 1'b1];
          end
        SSM_STWR:
          if (byte_end)
            state <= SSM_IGNORE;
        SSM_IGNORE:
          bit_cnt <= '0;
        default:
          state <= SSM_IGNORE;
      endcase
    end
  end
  // Byte array write, done on the byte's last rising edge
  always_ff @(posedge spi_sck_i)
  begin
    if (wr_strobe && !link_rst)
      array[addr] <= next_shift[7:0];
  end
  // Status register survives deselect
  // pin protect refuses write
  always_ff @(posedge spi_sck_i or posedge rst_i)
  begin
    if (rst_i)
      status <= `SSM_STATUS_RST;
    else if (rise_ok && !link_rst && state == SSM_STWR && byte_end &&
             !(status[`SSM_PPEN_POS] && !wp_n_i))
      status <= next_shift[7:0];
  end
  // Write report word and event toggle
  always_ff @(posedge spi_sck_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link_word <= '0;
      link_tgl  <= 1'b0;
    end
    else if (wr_strobe && !link_rst)
    begin
      link_word <= '{addr: addr, data: next_shift[7:0]};
      link_tgl  <= ~link_tgl;
    end
  end
  // Output data on falling serial clock
  // drive on fall
  always_ff @(negedge spi_sck_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      so_q   <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (rise_ok)
    begin
      so_q   <= rd_byte[3'h7 - bit_cnt[2:0]];
      oe_n_q <= (state != SSM_RDATA);
    end
  end
  assign spi_so_o      = so_q;
  assign spi_so_oe_n_o = oe_n_q | ~hold_n_i | spi_cs_n_i;
  // ----------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------
  logic [1:0]   tgl_sync;
  logic         tgl_seen;
  logic [1:0]   mode_sync;
  logic         pend;
  ssm_wr_word_t pend_word;
  logic         fifo_ready;
  logic         new_evt;
  // New write event seen
  assign new_evt = (tgl_sync[1] != tgl_seen);
  // Toggle and mode synchronisers
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tgl_sync  <= '0;
      tgl_seen  <= 1'b0;
      mode_sync <= '0;
      mode3_o   <= 1'b0;
    end
    else
    begin
      tgl_sync  <= {tgl_sync[0], link_tgl};
      tgl_seen  <= tgl_sync[1];
      mode_sync <= {mode_sync[0], mode3_link};
      mode3_o   <= mode_sync[1];
    end
  end
  // Pending word, stalled by FIFO back-pressure; overflow is flagged
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend      <= 1'b0;
      pend_word <= '0;
      wr_drop_o <= 1'b0;
    end
    else
    begin
      if (new_evt && pend && !fifo_ready)
        wr_drop_o <= 1'b1;
      if (new_evt)
      begin
        pend      <= 1'b1;
        pend_word <= link_word;
      end
      else if (fifo_ready)
        pend <= 1'b0;
    end
  end
  // Write log buffer
  ssm_fifo #(
    .WIDTH ($bits(ssm_wr_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pend),
    .in_ready_o  (fifo_ready),
    .in_data_i   (pend_word),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (wr_word_o)
  );
endmodule
